// *** src/wdtw_osc.sv ***
`timescale 1ns/1ps
`default_nettype none
module wdtw_osc
  import wdtw_pkg::*;
#(
  parameter int DIV = OSC_DIV
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  output var  logic tick
);
  localparam int CW = $clog2(DIV);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } wdtw_osc_st_type;

  wdtw_osc_st_type st_ff;
  wdtw_osc_st_type nxt_st;

  // oscillator stopped while the watchdog is off, saving power
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (!enable) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt == CW'(DIV - 1)) begin
      nxt_st.cnt  = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;
endmodule : wdtw_osc
`default_nettype wire

// *** src/wdtw_pkg.sv ***
// Behaviour
// - the watchdog runs from the low-power RC oscillator, which is switched on whenever the watchdog is enabled.
// - the prescaler divides the oscillator by 128 when prescale_select is 1 and by 32 when it is 0.
// - at the nominal 32 kHz the prescaler alone gives a base period of about 1 ms (by 32) or 4 ms (by 128).
// - the 4-bit postscale_select field picks a power-of-two ratio from 1:1 (0000) to 1:32,768 (1111).
// - counters clear on device reset, clock-switch completion, power-save entry and exit, and watchdog clear.
// - an enabled watchdog keeps counting in sleep and idle, and its timeout there wakes the core.
// - with force_enable_cfg at 1 the watchdog always runs and clearing soft_enable_bit does nothing.
// - with force_enable_cfg at 0 the watchdog runs only while soft_enable_bit (bit 5) is set; reset clears it.
// - with window_disable_cfg at 0 a clear before the final quarter of the period forces a device reset.
// - a timeout sets timeout_flag (bit 4), which only software or a device reset clears.
// - window_disable_cfg at 1 selects non-window operation, at 0 window operation.
package wdtw_pkg;
  localparam int CLK_HZ    = 20000000;
  localparam int OSC_HZ    = 32000;
  localparam int OSC_DIV   = CLK_HZ / OSC_HZ;
  localparam int PRE_SHORT = 32;
  localparam int PRE_LONG  = 128;
  localparam int PRE_W     = 7;
  localparam int POST_W    = 15;
  localparam int FINE_W    = 23;

  localparam logic [7:0] OFF_RESET_CTRL = 8'h00;
  localparam logic [7:0] OFF_CFG        = 8'h04;
  localparam logic [7:0] OFF_CMD        = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT   = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h10;
  localparam logic [7:0] OFF_COUNT      = 8'h14;

  localparam int BIT_IDLE    = 2;
  localparam int BIT_SLEEP   = 3;
  localparam int BIT_TIMEOUT = 4;
  localparam int BIT_SOFT_EN = 5;

  localparam int CFG_PRE    = 4;
  localparam int CFG_WINDOW_DISABLE_CFG = 6;
  localparam int CFG_FORCE  = 7;
  localparam logic [7:0] CFG_MASK  = 8'hDF;
  localparam logic [7:0] CFG_RESET = 8'hDF;

  localparam int CMD_CLEAR = 0;
  localparam int CMD_SLEEP = 1;
  localparam int CMD_IDLE  = 2;
  localparam int CMD_CLKSW = 3;

  localparam int EV_TIMEOUT = 0;
  localparam int EV_EARLY   = 1;
  localparam int EV_WAKE    = 2;
  localparam int EV_W       = 3;

  typedef enum logic [1:0] {
    PM_RUN   = 2'b00,
    PM_SLEEP = 2'b01,
    PM_IDLE  = 2'b10
  } wdtw_pmode_type;

  typedef enum logic [2:0] {
    RG_NONE  = 3'b000,
    RG_RCTL  = 3'b001,
    RG_CFG   = 3'b010,
    RG_CMD   = 3'b011,
    RG_STAT  = 3'b100,
    RG_MASK  = 3'b101,
    RG_COUNT = 3'b110
  } wdtw_reg_type;
endpackage : wdtw_pkg

// *** src/wdtw_scaler.sv ***
`timescale 1ns/1ps
`default_nettype none
module wdtw_scaler
  import wdtw_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              run,
  input  wire logic              clear,
  input  wire logic              tick,
  input  wire logic              pre_sel,
  input  wire logic [3:0]        post_sel,
  output var  logic [PRE_W-1:0]  pre_cnt,
  output var  logic [POST_W-1:0] post_cnt,
  output var  logic              timeout
);
  typedef struct packed {
    logic [PRE_W-1:0]  pre;
    logic [POST_W-1:0] post;
    logic              done;
  } wdtw_scl_st_type;

  wdtw_scl_st_type   st_ff;
  wdtw_scl_st_type   nxt_st;
  logic [PRE_W-1:0]  pre_last;
  logic [POST_W-1:0] post_last;

  assign pre_last  = pre_sel ? PRE_W'(PRE_LONG - 1) : PRE_W'(PRE_SHORT - 1);
  // code 1111 wraps to all ones, i.e. 1:32,768
  assign post_last = (POST_W'(1) << post_sel) - POST_W'(1);

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (clear || !run) begin
      nxt_st.pre  = '0;
      nxt_st.post = '0;
    end else if (tick) begin
      if (st_ff.pre >= pre_last) begin
        nxt_st.pre = '0;
        if (st_ff.post >= post_last) begin
          nxt_st.post = '0;
          nxt_st.done = 1'b1;
        end else begin
          nxt_st.post = st_ff.post + POST_W'(1);
        end
      end else begin
        nxt_st.pre = st_ff.pre + PRE_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pre_cnt  = st_ff.pre;
  assign post_cnt = st_ff.post;
  assign timeout  = st_ff.done;
endmodule : wdtw_scaler
`default_nettype wire

// *** src/wdtw_top.sv ***
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module wdtw_top
  import wdtw_pkg::*;
#(
  parameter int DIV = OSC_DIV
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        clk_switch_done,
  input  wire logic        ext_wake,
  output var  logic        osc_enable,
  output var  logic        reset_req,
  output var  logic        wake_req,
  output var  logic        irq
);
  typedef struct packed {
    wdtw_pmode_type  pmode;
    logic            soft_en;
    logic            sleep_f;
    logic            idle_f;
    logic            timeout_f;
    logic [7:0]      cfg;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic            ap_valid;
    logic            ap_write;
    logic [7:0]      ap_addr;
    logic [31:0]     rdata;
    logic            hready;
    logic            hresp;
    logic            clr;
    logic            osc_en;
    logic            rst_req;
    logic            wake;
    logic            irq;
  } wdtw_st_type;

  wdtw_st_type       st_ff;
  wdtw_st_type       nxt_st;
  logic              tick;
  logic              tmo;
  logic [PRE_W-1:0]  pre_cnt;
  logic [POST_W-1:0] post_cnt;
  logic              running;
  logic [15:0]       period;
  logic [FINE_W-1:0] fine;
  logic [FINE_W-1:0] total;
  logic              win_open;
  logic              wr_cmd;
  logic [31:0]       rd_word;

  function automatic wdtw_reg_type reg_decode(input logic [7:0] a);
    if (a == OFF_RESET_CTRL) begin
      return RG_RCTL;
    end else if (a == OFF_CFG) begin
      return RG_CFG;
    end else if (a == OFF_CMD) begin
      return RG_CMD;
    end else if (a == OFF_IRQ_STAT) begin
      return RG_STAT;
    end else if (a == OFF_IRQ_MASK) begin
      return RG_MASK;
    end else if (a == OFF_COUNT) begin
      return RG_COUNT;
    end else begin
      return RG_NONE;
    end
  endfunction : reg_decode

  // forced mode ignores soft_en entirely
  assign running = st_ff.cfg[CFG_FORCE] | st_ff.soft_en;

  wdtw_osc #(
    .DIV (DIV)
  ) u_osc (
    .clk    (clk),
    .rst_n  (rst_n),
    .enable (st_ff.osc_en),
    .tick   (tick)
  );

  wdtw_scaler u_scaler (
    .clk      (clk),
    .rst_n    (rst_n),
    .run      (running),
    .clear    (st_ff.clr),
    .tick     (tick),
    .pre_sel  (st_ff.cfg[CFG_PRE]),
    .post_sel (st_ff.cfg[3:0]),
    .pre_cnt  (pre_cnt),
    .post_cnt (post_cnt),
    .timeout  (tmo)
  );

  // elapsed time in oscillator ticks against the full period
  assign period = 16'h0001 << st_ff.cfg[3:0];
  assign fine   = st_ff.cfg[CFG_PRE] ? {1'b0, post_cnt, pre_cnt}
                                     : {3'b000, post_cnt, pre_cnt[4:0]};
  assign total  = st_ff.cfg[CFG_PRE] ? {period, 7'h00} : {2'b00, period, 5'h00};
  assign win_open = fine >= (total - (total >> 2));

  assign wr_cmd = st_ff.ap_valid && st_ff.ap_write && (reg_decode(st_ff.ap_addr) == RG_CMD);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (reg_decode(haddr[7:0]))
      RG_RCTL: begin
        rd_word[BIT_IDLE]    = st_ff.idle_f;
        rd_word[BIT_SLEEP]   = st_ff.sleep_f;
        rd_word[BIT_TIMEOUT] = st_ff.timeout_f;
        rd_word[BIT_SOFT_EN] = st_ff.soft_en;
      end
      RG_CFG:   rd_word[7:0] = st_ff.cfg;
      RG_STAT:  rd_word[EV_W-1:0] = st_ff.irq_stat;
      RG_MASK:  rd_word[EV_W-1:0] = st_ff.irq_mask;
      RG_COUNT: rd_word = {2'b00, st_ff.pmode, 5'h00, post_cnt, 1'b0, pre_cnt};
      default:  rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] w1c;
    logic [31:0]     wd;
    wdtw_reg_type    wr;
    ev             = '0;
    w1c            = '0;
    wd             = hwdata;
    wr             = RG_NONE;
    nxt_st         = st_ff;
    nxt_st.clr     = 1'b0;
    nxt_st.rst_req = 1'b0;
    nxt_st.wake    = 1'b0;
    nxt_st.hready  = 1'b1;
    nxt_st.hresp   = 1'b0;
    if (st_ff.ap_valid && st_ff.ap_write) begin
      wr = reg_decode(st_ff.ap_addr);
    end

    if (wr == RG_RCTL) begin
      // flags are plain writes; hardware sets below win
      nxt_st.idle_f    = wd[BIT_IDLE];
      nxt_st.sleep_f   = wd[BIT_SLEEP];
      nxt_st.timeout_f = wd[BIT_TIMEOUT];
      nxt_st.soft_en   = wd[BIT_SOFT_EN];
    end else if (wr == RG_CFG) begin
      nxt_st.cfg = wd[7:0] & CFG_MASK;
    end else if (wr == RG_STAT) begin
      w1c = wd[EV_W-1:0];
    end else if (wr == RG_MASK) begin
      nxt_st.irq_mask = wd[EV_W-1:0];
    end

    if (clk_switch_done || (wr_cmd && wd[CMD_CLKSW])) begin
      nxt_st.clr = 1'b1;
    end

    case (st_ff.pmode)
      PM_RUN: begin
        if (wr_cmd && wd[CMD_CLEAR]) begin
          nxt_st.clr = 1'b1;
          // window mode: too early a clear is a watchdog reset
          if (running && !st_ff.cfg[CFG_WINDOW_DISABLE_CFG] && !win_open) begin
            nxt_st.rst_req   = 1'b1;
            nxt_st.timeout_f = 1'b1;
            ev[EV_EARLY]     = 1'b1;
          end
        end
        if (wr_cmd && (wd[CMD_SLEEP] || wd[CMD_IDLE])) begin
          nxt_st.clr = 1'b1;
          if (wd[CMD_SLEEP]) begin
            nxt_st.pmode   = PM_SLEEP;
            nxt_st.sleep_f = 1'b1;
          end else begin
            nxt_st.pmode  = PM_IDLE;
            nxt_st.idle_f = 1'b1;
          end
        end
        if (tmo) begin
          nxt_st.rst_req   = 1'b1;
          nxt_st.timeout_f = 1'b1;
          ev[EV_TIMEOUT]   = 1'b1;
        end
      end
      PM_SLEEP, PM_IDLE: begin
        // counting goes on; a timeout wakes instead of resetting
        if (tmo) begin
          nxt_st.timeout_f = 1'b1;
          nxt_st.wake      = 1'b1;
          nxt_st.pmode     = PM_RUN;
          nxt_st.clr       = 1'b1;
          ev[EV_TIMEOUT]   = 1'b1;
          ev[EV_WAKE]      = 1'b1;
        end else if (ext_wake) begin
          nxt_st.pmode = PM_RUN;
          nxt_st.clr   = 1'b1;
        end
      end
      default: nxt_st.pmode = PM_RUN;
    endcase

    nxt_st.irq_stat = (st_ff.irq_stat & ~w1c) | ev;
    nxt_st.irq      = |(nxt_st.irq_stat & nxt_st.irq_mask);
    nxt_st.osc_en   = running;

    // zero-wait slave: read data fetched in the address phase
    nxt_st.ap_valid = hsel && htrans[1] && hready;
    nxt_st.ap_write = hwrite;
    nxt_st.ap_addr  = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      nxt_st.rdata = rd_word;
    end else begin
      nxt_st.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff        <= '0;
      st_ff.pmode  <= PM_RUN;
      st_ff.cfg    <= CFG_RESET;
      st_ff.hready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout  = st_ff.hready;
  assign hresp      = st_ff.hresp;
  assign hrdata     = st_ff.rdata;
  assign osc_enable = st_ff.osc_en;
  assign reset_req  = st_ff.rst_req;
  assign wake_req   = st_ff.wake;
  assign irq        = st_ff.irq;

  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, haddr[31:8]};

  // two cycles: the oscillator flop still sits in reset at the release edge
  a_osc_follows_en: assert property (
    @(posedge clk) disable iff (!rst_n)
    running ##1 running |=> osc_enable)
    else $error("oscillator not enabled while watchdog runs");

  a_prescale_span: assert property (
    @(posedge clk) disable iff (!rst_n)
    !st_ff.cfg[CFG_PRE] |-> pre_cnt < 7'h20)
    else $error("short prescaler exceeded 32 counts");

  a_postscale_span: assert property (
    @(posedge clk) disable iff (!rst_n)
    {1'b0, post_cnt} < period)
    else $error("postscaler beyond selected ratio");

  a_clear_zeroes: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_ff.clr |=> (pre_cnt == 7'h00) && (post_cnt == 15'h0000))
    else $error("counters not cleared");

  a_sleep_wakes: assert property (
    @(posedge clk) disable iff (!rst_n)
    tmo && (st_ff.pmode != PM_RUN) |=> wake_req && (st_ff.pmode == PM_RUN) ##1 !wake_req)
    else $error("timeout in power save did not wake");

  a_forced_runs: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_ff.cfg[CFG_FORCE] |-> running)
    else $error("forced watchdog not running");

  a_soft_off_stops: assert property (
    @(posedge clk) disable iff (!rst_n)
    !running ##1 !running |-> !osc_enable && (pre_cnt == 7'h00))
    else $error("disabled watchdog still counting");

  a_early_clear_rst: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_cmd && hwdata[CMD_CLEAR] && running && (st_ff.pmode == PM_RUN)
      && !st_ff.cfg[CFG_WINDOW_DISABLE_CFG] && !win_open |=> reset_req && st_ff.irq_stat[EV_EARLY])
    else $error("early clear in window mode did not reset");

  a_nowin_no_rst: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_cmd && hwdata[CMD_CLEAR] && st_ff.cfg[CFG_WINDOW_DISABLE_CFG] && !tmo |=> !reset_req)
    else $error("clear in non-window mode caused reset");

  a_flag_sticky: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_ff.timeout_f && !(st_ff.ap_valid && st_ff.ap_write) |=> st_ff.timeout_f)
    else $error("timeout flag cleared by hardware");

  a_run_tmo_reset: assert property (
    @(posedge clk) disable iff (!rst_n)
    tmo && (st_ff.pmode == PM_RUN) |=> reset_req && st_ff.timeout_f ##1 !reset_req)
    else $error("run-mode timeout without reset request");

  a_clksw_clears: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_switch_done |=> st_ff.clr ##1 (pre_cnt == 7'h00) && (post_cnt == 15'h0000))
    else $error("clock switch did not clear the counters");

  a_enter_save: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_cmd && hwdata[CMD_SLEEP] && (st_ff.pmode == PM_RUN)
      |=> (st_ff.pmode == PM_SLEEP) && st_ff.sleep_f && st_ff.clr)
    else $error("sleep entry did not set flag and clear counters");

  a_save_no_reset: assert property (
    @(posedge clk) disable iff (!rst_n)
    tmo && (st_ff.pmode != PM_RUN) |=> !reset_req)
    else $error("timeout in power save requested a reset");

  a_late_clear_ok: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_cmd && hwdata[CMD_CLEAR] && (st_ff.pmode == PM_RUN) && win_open && !tmo
      |=> !reset_req)
    else $error("clear inside the window caused reset");

  a_tmo_sets_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    tmo |=> st_ff.timeout_f && st_ff.irq_stat[EV_TIMEOUT])
    else $error("timeout did not set the flags");

  c_run_timeout: cover property (
    @(posedge clk) disable iff (!rst_n) tmo && (st_ff.pmode == PM_RUN));
  c_sleep_wake: cover property (
    @(posedge clk) disable iff (!rst_n) wake_req);
  c_early_clear: cover property (
    @(posedge clk) disable iff (!rst_n) $rose(st_ff.irq_stat[EV_EARLY]));
  c_irq_raised: cover property (
    @(posedge clk) disable iff (!rst_n) $rose(irq));
  c_late_clear: cover property (
    @(posedge clk) disable iff (!rst_n) wr_cmd && hwdata[CMD_CLEAR] && win_open);
endmodule : wdtw_top
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wdtw_pkg::*;
  localparam int D = 2;
  typedef struct packed {
    logic [7:0]  addr;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } wdtw_row_type;
  localparam wdtw_row_type ROWS [9] = '{
    '{8'h04, 1'b1, 32'hFFFFFFFF, 32'h000000DF},
    '{8'h04, 1'b1, 32'h00000055, 32'h00000055},
    '{8'h04, 1'b1, 32'h000000DF, 32'h000000DF},
    '{8'h10, 1'b1, 32'hFFFFFFFF, 32'h00000007},
    '{8'h10, 1'b1, 32'h00000000, 32'h00000000},
    '{8'h00, 1'b1, 32'h0000003C, 32'h0000003C},
    '{8'h00, 1'b1, 32'h00000000, 32'h00000000},
    '{8'h08, 1'b0, 32'h00000000, 32'h00000000},
    '{8'h40, 1'b1, 32'hFFFFFFFF, 32'h00000000}
  };
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        csw;
  logic        xwake;
  logic        osc_en;
  logic        rreq;
  logic        wreq;
  logic        irq;
  logic [31:0] rd;
  logic        rr;
  logic        wk;
  int          n;
  int          fails;
  int          num_checks;

  wdtw_top #(.DIV(D)) u_dut (
    .clk             (clk),
    .rst_n           (rst_n),
    .hsel            (hsel),
    .haddr           (haddr),
    .htrans          (htrans),
    .hwrite          (hwrite),
    .hsize           (hsize),
    .hwdata          (hwdata),
    .hready          (hready),
    .hreadyout       (hready),
    .hresp           (hresp),
    .hrdata          (hrdata),
    .clk_switch_done (csw),
    .ext_wake        (xwake),
    .osc_enable      (osc_en),
    .reset_req       (rreq),
    .wake_req        (wreq),
    .irq             (irq)
  );

  always #25 clk = ~clk;

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // single transfer; the one slave's ready is the bus ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'h2;
    haddr  <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    check("hresp", 32'h0, {31'h0, hresp});
  endtask : xfer

  task automatic wait_ev(input int mx);
    n  = 0;
    rr = 1'b0;
    wk = 1'b0;
    while (n < mx && !rr && !wk) begin
      @(posedge clk);
      n++;
      rr = (rreq === 1'b1);
      wk = (wreq === 1'b1);
    end
  endtask : wait_ev

  // t is the period in oscillator ticks; tick phase and pipeline give the slack
  task automatic expect_tmo(input int t, input logic is_wake);
    wait_ev(t * D + 30);
    check("wake", {31'h0, is_wake}, {31'h0, wk});
    check("reset_req", {31'h0, ~is_wake}, {31'h0, rr});
    check("period", 32'h1, {31'h0, n >= t * D - D && n <= t * D + D + 6});
  endtask : expect_tmo

  task automatic pulse_csw();
    @(posedge clk);
    csw <= 1'b1;
    @(posedge clk);
    csw <= 1'b0;
  endtask : pulse_csw

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    clk = 1'b0; rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
    hwrite = 1'b0; hwdata = 32'h0; csw = 1'b0; xwake = 1'b0;
    hsize = 3'h0;
    fails = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check("osc_en", 32'h1, {31'h0, osc_en});
    xfer(1'b0, 8'h00, 32'h0);
    check("rctl_rst", 32'h0, rd);
    for (int i = 0; i < 9; i++) begin
      if (ROWS[i].wr) xfer(1'b1, ROWS[i].addr, ROWS[i].wdata);
      xfer(1'b0, ROWS[i].addr, 32'h0);
      check("reg", ROWS[i].exp, rd);
    end
    // period for each prescale and the low postscale codes
    xfer(1'b1, 8'h00, 32'h20);
    for (int p = 0; p < 2; p++) begin
      for (int q = 0; q < 3; q++) begin
        xfer(1'b1, 8'h04, 32'h40 | (p << 4) | q);
        xfer(1'b1, 8'h08, 32'h1);
        expect_tmo((p ? 128 : 32) << q, 1'b0);
      end
    end
    xfer(1'b0, 8'h00, 32'h0);
    check("tmo_flag", 32'h30, rd);
    xfer(1'b1, 8'h08, 32'h1);
    xfer(1'b0, 8'h00, 32'h0);
    check("tmo_sticky", 32'h30, rd);
    xfer(1'b1, 8'h00, 32'h20);
    // clock switch mid-period restarts the count
    xfer(1'b1, 8'h04, 32'h40);
    xfer(1'b1, 8'h08, 32'h1);
    repeat (40) @(posedge clk);
    pulse_csw();
    expect_tmo(32, 1'b0);
    // the clock-switch command bit restarts the count the same way
    repeat (40) @(posedge clk);
    xfer(1'b1, 8'h08, 32'h8);
    expect_tmo(32, 1'b0);
    // forced on: soft enable has no effect
    xfer(1'b1, 8'h04, 32'hC0);
    xfer(1'b1, 8'h00, 32'h0);
    repeat (3) @(posedge clk);
    check("osc_force", 32'h1, {31'h0, osc_en});
    xfer(1'b1, 8'h08, 32'h1);
    expect_tmo(32, 1'b0);
    xfer(1'b1, 8'h04, 32'h40);
    repeat (3) @(posedge clk);
    check("osc_off", 32'h0, {31'h0, osc_en});
    wait_ev(300);
    check("no_tmo", 32'h0, {31'h0, rr});
    // window mode: early clear resets, late clear does not
    xfer(1'b1, 8'h04, 32'h01);
    xfer(1'b1, 8'h00, 32'h20);
    pulse_csw();
    xfer(1'b1, 8'h0C, 32'h7);
    xfer(1'b1, 8'h08, 32'h1);
    wait_ev(6);
    check("early_clr", 32'h1, {31'h0, rr});
    xfer(1'b0, 8'h0C, 32'h0);
    check("early_stat", 32'h1, {31'h0, rd[1]});
    repeat (100) @(posedge clk);
    xfer(1'b1, 8'h08, 32'h1);
    wait_ev(8);
    check("late_clr", 32'h0, {31'h0, rr});
    // sleep and idle: timeout wakes instead of resetting
    xfer(1'b1, 8'h04, 32'h40);
    for (int i = 0; i < 2; i++) begin
      xfer(1'b1, 8'h00, 32'h20);
      xfer(1'b1, 8'h08, i ? 32'h4 : 32'h2);
      expect_tmo(32, 1'b1);
      xfer(1'b0, 8'h00, 32'h0);
      check("pm_flags", i ? 32'h34 : 32'h38, rd);
      xfer(1'b0, 8'h14, 32'h0);
      check("pm_mode", 32'h0, {30'h0, rd[29:28]});
    end
    xfer(1'b1, 8'h00, 32'h20);
    xfer(1'b1, 8'h08, 32'h2);
    xfer(1'b0, 8'h14, 32'h0);
    check("sleep_mode", 32'h1, {30'h0, rd[29:28]});
    @(posedge clk);
    xwake <= 1'b1;
    @(posedge clk);
    xwake <= 1'b0;
    xfer(1'b0, 8'h14, 32'h0);
    check("xwake_mode", 32'h0, {30'h0, rd[29:28]});
    // interrupt: raise, mask, clear
    xfer(1'b1, 8'h0C, 32'h7);
    xfer(1'b1, 8'h10, 32'h1);
    xfer(1'b1, 8'h08, 32'h1);
    expect_tmo(32, 1'b0);
    xfer(1'b1, 8'h00, 32'h0);
    check("irq_on", 32'h1, {31'h0, irq});
    xfer(1'b1, 8'h10, 32'h0);
    repeat (2) @(posedge clk);
    check("irq_masked", 32'h0, {31'h0, irq});
    xfer(1'b1, 8'h10, 32'h1);
    repeat (2) @(posedge clk);
    check("irq_unmask", 32'h1, {31'h0, irq});
    xfer(1'b1, 8'h0C, 32'h1);
    repeat (2) @(posedge clk);
    check("irq_w1c", 32'h0, {31'h0, irq});
    // second reset in mid-run clears soft enable and returns config to 0xDF
    xfer(1'b1, 8'h00, 32'h20);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    check("rst_osc", 32'h0, {31'h0, osc_en});
    rst_n <= 1'b1;
    xfer(1'b0, 8'h00, 32'h0);
    check("rctl_rst2", 32'h0, rd);
    xfer(1'b0, 8'h04, 32'h0);
    check("cfg_rst2", 32'hDF, rd);
    conclude();
  end
endmodule : tb
`default_nettype wire
